// >>> src/bsc_core.sv
// Strap decoding, setpoint ramping, mode and clock selection with an APB register file.
// How it works
// - Frequency strap picks one of four frequencies.
// - Upper strap bit sampled, both switches open.
// - Upper zero: close switch one, sense.
// - Upper one: close switch two, sense.
// - Range code picks 1.25, 2.5, 5 mV.
// - Range defaults to widest 5 mV range.
// - New range waits for setpoint write.
// - Output equals 0.4 V plus code times step.
// - Setpoint strap gives default code and address.
// - Changes during soft-start wait until it ends.
// - Changes while disabled apply at enable.
// - Changes during any ramp wait for completion.
// - Strap setpoint is first soft-start target.
// - Setpoint moves ramp at selected slew rate.
// - Static mode level picks forced or power-save.
// - Valid external clock aligns and forces PWM.
// - Pin request ORed with forced PWM bit.
// - Spread varies frequency ten percent triangularly.
// - Spread needs bit, forced PWM, no sync.
// - Secondary device takes clock from pin.
// - Soft-start time field picks four durations.
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module bsc_core import bsc_pkg::*; (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic i_freq_strap,
    input wire logic i_setpoint_strap,
    input wire logic i_enable,
    input wire logic i_mode_sync,
    input wire logic i_stack_secondary,
    output logic o_pready,
    output logic o_pslverr,
    output logic [31:0] o_prdata,
    output logic o_freq_sw_one,
    output logic o_freq_sw_two,
    output logic o_setp_sw_one,
    output logic o_setp_sw_two,
    output logic o_init_done,
    output logic [1:0] o_freq_sel,
    output logic [6:0] o_target_addr,
    output logic [9:0] o_vout_fine,
    output logic o_soft_start,
    output logic o_ramping,
    output logic o_forced_pwm,
    output logic o_sync_pulse,
    output logic o_ext_clock,
    output logic signed [4:0] o_freq_trim,
    output logic o_droop_en
);
    typedef enum logic [1:0] {SP_MSB, SP_LSB, SP_DONE} bsc_strap_t;
    typedef enum logic [2:0] {RS_INIT, RS_OFF, RS_SS, RS_ON, RS_DVS} bsc_ramp_t;
    ////////////////////////////////////////
    // Pin synchronisers: only the second stage is read.
    logic [4:0] pin_s1_r, pin_s2_r;
    logic fq_lvl, vs_lvl, en_lvl, mode_lvl, sec_lvl;
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            pin_s1_r <= 5'h00;
            pin_s2_r <= 5'h00;
        end else begin
            pin_s1_r <= {i_stack_secondary, i_mode_sync, i_enable,
                         i_setpoint_strap, i_freq_strap};
            pin_s2_r <= pin_s1_r;
        end
    end
    assign {sec_lvl, mode_lvl, en_lvl, vs_lvl, fq_lvl} = pin_s2_r;
    ////////////////////////////////////////
    // Resistor level decoder, one sequence serves both straps.
    bsc_strap_t sp_r;
    logic [15:0] settle_r;
    logic fq_msb_r, vs_msb_r, init_done_r, load_strap_r, settled;
    logic [1:0] fq_idx_r, vs_idx_r;
    assign settled = (settle_r == 16'(STRAP_SETTLE_CYC - 1));
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            sp_r <= SP_MSB;
            settle_r <= 16'h0000;
            fq_msb_r <= 1'b0;
            vs_msb_r <= 1'b0;
            fq_idx_r <= 2'h0;
            vs_idx_r <= 2'h0;
            init_done_r <= 1'b0;
            load_strap_r <= 1'b0;
            o_freq_sw_one <= 1'b0;
            o_freq_sw_two <= 1'b0;
            o_setp_sw_one <= 1'b0;
            o_setp_sw_two <= 1'b0;
        end else begin
            load_strap_r <= 1'b0;
            settle_r <= settled ? 16'h0000 : settle_r + 16'h0001;
            unique case (sp_r)
                SP_MSB: begin
                    if (settled) begin
                        fq_msb_r <= fq_lvl;
                        vs_msb_r <= vs_lvl;
                        o_freq_sw_one <= ~fq_lvl;
                        o_freq_sw_two <= fq_lvl;
                        o_setp_sw_one <= ~vs_lvl;
                        o_setp_sw_two <= vs_lvl;
                        sp_r <= SP_LSB;
                    end
                end
                SP_LSB: begin
                    if (settled) begin
                        fq_idx_r <= strap_idx({fq_msb_r, fq_lvl});
                        vs_idx_r <= strap_idx({vs_msb_r, vs_lvl});
                        o_freq_sw_one <= 1'b0;
                        o_freq_sw_two <= 1'b0;
                        o_setp_sw_one <= 1'b0;
                        o_setp_sw_two <= 1'b0;
                        init_done_r <= 1'b1;
                        load_strap_r <= 1'b1;
                        sp_r <= SP_DONE;
                    end
                end
                SP_DONE: begin
                    // Held until the next power-up reset; no rescan.
                    settle_r <= 16'h0000;
                end
            endcase
        end
    end
    logic [7:0] strap_code;
    logic [6:0] strap_addr;
    always_comb begin
        unique case (vs_idx_r)
            2'h0: begin strap_code = 8'h50; strap_addr = 7'h44; end
            2'h1: begin strap_code = 8'h46; strap_addr = 7'h45; end
            2'h2: begin strap_code = 8'h5f; strap_addr = 7'h46; end
            default: begin strap_code = 8'h24; strap_addr = 7'h47; end
        endcase
    end
    ////////////////////////////////////////
    // APB slave; every access answers in its second access cycle.
    bsc_ctrl1_t ctrl1_r;
    logic [1:0] sst_r, range_lat_r;
    logic droop_r, wr_ok, rd_hit;
    logic [7:0] setp_r;
    logic [31:0] rd_val, status_w;
    assign wr_ok = i_psel & i_penable & o_pready & i_pwrite;
    always_comb begin
        rd_hit = 1'b1;
        rd_val = 32'h0000_0000;
        unique case (i_paddr)
            OFS_CTRL1: rd_val = {26'h0, ctrl1_r};
            OFS_CTRL2: rd_val = {30'h0, sst_r};
            OFS_CTRL3: rd_val = {31'h0, droop_r};
            OFS_SETP: rd_val = {24'h0, setp_r};
            OFS_STAT: rd_val = status_w;
            OFS_VOUT: rd_val = {22'h0, o_vout_fine};
            default: rd_hit = 1'b0;
        endcase
    end
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0000_0000;
        end else begin
            o_pready <= i_psel & i_penable & ~o_pready;
            o_pslverr <= i_psel & i_penable & ~o_pready & ~rd_hit;
            if (i_psel & i_penable & ~o_pready & ~i_pwrite) begin
                o_prdata <= rd_val;
            end
        end
    end
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            ctrl1_r <= CTRL1_RST;
            sst_r <= SST_RST;
            droop_r <= 1'b0;
        end else if (wr_ok) begin
            if (i_paddr == OFS_CTRL1) begin
                ctrl1_r <= bsc_ctrl1_t'(i_pwdata[5:0]);
            end
            if (i_paddr == OFS_CTRL2) begin
                sst_r <= i_pwdata[1:0];
            end
            if (i_paddr == OFS_CTRL3) begin
                // Applied at once; the host keeps it to disabled periods.
                droop_r <= i_pwdata[0];
            end
        end
    end
    // A setpoint write also captures the range now in force.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            setp_r <= 8'h00;
            range_lat_r <= RANGE_RST;
        end else begin
            if (load_strap_r) begin
                setp_r <= strap_code;
            end else if (wr_ok && i_paddr == OFS_SETP) begin
                setp_r <= i_pwdata[7:0];
                range_lat_r <= ctrl1_r.range_field;
            end
        end
    end
    ////////////////////////////////////////
    // Setpoint engine: soft-start, then controlled moves.
    bsc_ramp_t rs_r;
    bsc_act_t act_r;
    logic [9:0] cur_r, ss_phase_r, act_fine, new_fine;
    logic [15:0] tick_r, tick_lim;
    logic [19:0] ss_prod;
    logic tick;
    assign act_fine = fine_of(act_r.code, act_r.range);
    assign new_fine = fine_of(setp_r, range_lat_r);
    assign ss_prod = act_fine * ss_phase_r;
    assign tick = (tick_r >= tick_lim);
    always_comb begin
        tick_lim = 16'h0001;
        if (rs_r == RS_SS) begin
            unique case (act_r.sst)
                2'h0: tick_lim = 16'(SS_C0 - 1);
                2'h1: tick_lim = 16'(SS_C1 - 1);
                2'h2: tick_lim = 16'(SS_C2 - 1);
                default: tick_lim = 16'(SS_C3 - 1);
            endcase
        end else begin
            unique case (act_r.ramp)
                2'h0: tick_lim = 16'(DVS_C0 - 1);
                2'h1: tick_lim = 16'(DVS_C1 - 1);
                2'h2: tick_lim = 16'(DVS_C2 - 1);
                default: tick_lim = 16'(DVS_C3 - 1);
            endcase
        end
    end
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            rs_r <= RS_INIT;
            act_r <= '{8'h00, RANGE_RST, RAMP_RST, SST_RST};
            cur_r <= 10'h000;
            ss_phase_r <= 10'h000;
            tick_r <= 16'h0000;
        end else begin
            tick_r <= tick ? 16'h0000 : tick_r + 16'h0001;
            if (rs_r != RS_INIT && !en_lvl) begin
                rs_r <= RS_OFF;
                cur_r <= 10'h000;
            end
            unique case (rs_r)
                RS_INIT: begin
                    if (init_done_r) begin
                        rs_r <= RS_OFF;
                    end
                end
                RS_OFF: begin
                    // Stored values follow the registers until enable.
                    act_r <= '{setp_r, range_lat_r, ctrl1_r.ramp_rate_field,
                               sst_r};
                    ss_phase_r <= 10'h000;
                    tick_r <= 16'h0000;
                    if (en_lvl && !load_strap_r) begin
                        rs_r <= RS_SS;
                    end
                end
                RS_SS: begin
                    // Targets stay frozen here; new writes wait for RS_ON.
                    if (en_lvl && tick) begin
                        ss_phase_r <= ss_phase_r + 10'h001;
                        cur_r <= ss_prod[19:10];
                        if (&ss_phase_r) begin
                            cur_r <= act_fine;
                            rs_r <= RS_ON;
                        end
                    end
                end
                RS_ON: begin
                    if (en_lvl) begin
                        act_r <= '{setp_r, range_lat_r, ctrl1_r.ramp_rate_field,
                                   sst_r};
                        if (new_fine != cur_r) begin
                            tick_r <= 16'h0000;
                            rs_r <= RS_DVS;
                        end
                    end
                end
                RS_DVS: begin
                    if (en_lvl && tick) begin
                        if (cur_r < act_fine) begin
                            cur_r <= cur_r + 10'h001;
                        end else if (cur_r > act_fine) begin
                            cur_r <= cur_r - 10'h001;
                        end
                        if ((cur_r == act_fine + 10'h001) || (cur_r + 10'h001 == act_fine)
                            || (cur_r == act_fine)) begin
                            rs_r <= RS_ON;
                        end
                    end
                end
                default: rs_r <= RS_INIT;
            endcase
        end
    end
    ////////////////////////////////////////
    // External clock detection on the mode pin.
    logic mode_prev_r, sync_on, mode_rise, forced_pwm_mode_req, ssc_on, tri_up_r;
    logic [15:0] per_r, ssc_cnt_r;
    logic [1:0] good_r;
    assign mode_rise = mode_lvl & ~mode_prev_r;
    assign sync_on = (good_r == SYNC_GOOD);
    // Pin level, sync clock and register bit all ask for forced PWM.
    assign forced_pwm_mode_req = sync_on | sec_lvl | (mode_lvl & ~sync_on)
                      | ctrl1_r.forced_pwm_bit;
    assign ssc_on = ctrl1_r.spread_enable_bit & forced_pwm_mode_req & ~sync_on
                    & ~sec_lvl;
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            mode_prev_r <= 1'b0;
            per_r <= 16'h0000;
            good_r <= 2'h0;
        end else begin
            mode_prev_r <= mode_lvl;
            if (mode_rise) begin
                per_r <= 16'h0000;
                if (per_r >= 16'(SYNC_MIN_CYC) && per_r <= 16'(SYNC_MAX_CYC)) begin
                    good_r <= sync_on ? good_r : good_r + 2'h1;
                end else begin
                    good_r <= 2'h0;
                end
            end else if (per_r > 16'(SYNC_MAX_CYC)) begin
                // A static level after a lost clock falls back to mode select.
                good_r <= 2'h0;
            end else begin
                per_r <= per_r + 16'h0001;
            end
        end
    end
    ////////////////////////////////////////
    // Triangular frequency trim for spread spectrum.
    logic signed [4:0] tri_r;
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            tri_r <= 5'sd0;
            tri_up_r <= 1'b1;
            ssc_cnt_r <= 16'h0000;
        end else if (!ssc_on) begin
            tri_r <= 5'sd0;
            tri_up_r <= 1'b1;
            ssc_cnt_r <= 16'h0000;
        end else if (ssc_cnt_r == 16'(SSC_STEP_CYC - 1)) begin
            ssc_cnt_r <= 16'h0000;
            if (tri_up_r) begin
                tri_r <= tri_r + 5'sd1;
                tri_up_r <= (tri_r + 5'sd1 != SSC_PCT);
            end else begin
                tri_r <= tri_r - 5'sd1;
                tri_up_r <= (tri_r - 5'sd1 == -SSC_PCT);
            end
        end else begin
            ssc_cnt_r <= ssc_cnt_r + 16'h0001;
        end
    end
    ////////////////////////////////////////
    // Status word and registered outputs.
    assign status_w = {15'h0, o_soft_start, o_freq_trim != 5'sd0 || ssc_on,
                       o_forced_pwm, o_ext_clock, o_ramping, o_init_done,
                       o_target_addr, vs_idx_r, fq_idx_r};
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_init_done <= 1'b0;
            o_freq_sel <= 2'h0;
            o_target_addr <= 7'h00;
            o_vout_fine <= 10'h000;
            o_soft_start <= 1'b0;
            o_ramping <= 1'b0;
            o_forced_pwm <= 1'b0;
            o_sync_pulse <= 1'b0;
            o_ext_clock <= 1'b0;
            o_freq_trim <= 5'sd0;
            o_droop_en <= 1'b0;
        end else begin
            o_init_done <= init_done_r;
            o_freq_sel <= fq_idx_r;
            o_target_addr <= init_done_r ? strap_addr : 7'h00;
            o_vout_fine <= cur_r;
            o_soft_start <= (rs_r == RS_SS);
            o_ramping <= (rs_r == RS_SS) | (rs_r == RS_DVS);
            // Start-up always allows power-save behaviour.
            o_forced_pwm <= forced_pwm_mode_req & (rs_r != RS_SS);
            o_sync_pulse <= mode_rise & (sync_on | sec_lvl);
            o_ext_clock <= sync_on | sec_lvl;
            o_freq_trim <= tri_r;
            o_droop_en <= droop_r;
        end
    end
endmodule : bsc_core
`default_nettype wire

// >>> inc/bsc_pkg.sv
// Constants, field layouts and helpers for the buck setpoint and clock configuration block.
package bsc_pkg;
    localparam int CLK_MHZ = 200;
    // Strap sensing: settle time before each sample.
    localparam int STRAP_SETTLE_NS = 1000;
    localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS * CLK_MHZ + 999) / 1000;
    // Soft-start durations, in us, and cycles per step of a 1024-step ramp.
    localparam int SS_STEPS_LOG2 = 10;
    localparam int SS_T0_US = 500;
    localparam int SS_T1_US = 770;
    localparam int SS_T2_US = 1000;
    localparam int SS_T3_US = 2000;
    localparam int SS_C0 = SS_T0_US * CLK_MHZ / (1 << SS_STEPS_LOG2);
    localparam int SS_C1 = SS_T1_US * CLK_MHZ / (1 << SS_STEPS_LOG2);
    localparam int SS_C2 = SS_T2_US * CLK_MHZ / (1 << SS_STEPS_LOG2);
    localparam int SS_C3 = SS_T3_US * CLK_MHZ / (1 << SS_STEPS_LOG2);
    // Ramp rates in uV/us; one fine step is 1.25 mV.
    localparam int FINE_UV = 1250;
    localparam int RATE0_UV = 10000;
    localparam int RATE1_UV = 5000;
    localparam int RATE2_UV = 1250;
    localparam int RATE3_UV = 500;
    localparam int DVS_C0 = FINE_UV * CLK_MHZ / RATE0_UV;
    localparam int DVS_C1 = FINE_UV * CLK_MHZ / RATE1_UV;
    localparam int DVS_C2 = FINE_UV * CLK_MHZ / RATE2_UV;
    localparam int DVS_C3 = FINE_UV * CLK_MHZ / RATE3_UV;
    // Accepted external clock window and spread modulation.
    localparam int SYNC_MIN_KHZ = 1000;
    localparam int SYNC_MAX_KHZ = 4000;
    localparam int SYNC_MIN_CYC = CLK_MHZ * 1000 / SYNC_MAX_KHZ;
    localparam int SYNC_MAX_CYC = CLK_MHZ * 1000 / SYNC_MIN_KHZ;
    localparam logic [1:0] SYNC_GOOD = 2'h2;
    localparam logic signed [4:0] SSC_PCT = 5'sd10;
    localparam int SSC_STEP_NS = 2500;
    localparam int SSC_STEP_CYC = SSC_STEP_NS * CLK_MHZ / 1000;
    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL1 = 8'h00;
    localparam logic [7:0] OFS_CTRL2 = 8'h04;
    localparam logic [7:0] OFS_CTRL3 = 8'h08;
    localparam logic [7:0] OFS_SETP = 8'h0c;
    localparam logic [7:0] OFS_STAT = 8'h10;
    localparam logic [7:0] OFS_VOUT = 8'h14;
    // Field positions of the status word.
    localparam int ST_FREQ = 0;
    localparam int ST_SETPOINT_STRAP = 2;
    localparam int ST_ADDR = 4;
    localparam int ST_INIT = 11;
    localparam int ST_RAMP = 12;
    localparam int ST_SYNC = 13;
    localparam int ST_FORCED_PWM_MODE = 14;
    localparam int ST_SSC = 15;
    localparam int ST_SOFT = 16;
    // Reset values.
    localparam logic [1:0] RANGE_RST = 2'h2;
    localparam logic [1:0] RAMP_RST = 2'h2;
    localparam logic [1:0] SST_RST = 2'h2;
    typedef struct packed {
        logic spread_enable_bit;
        logic forced_pwm_bit;
        logic [1:0] ramp_rate_field;
        logic [1:0] range_field;
    } bsc_ctrl1_t;
    localparam bsc_ctrl1_t CTRL1_RST = '{1'b0, 1'b0, RAMP_RST, RANGE_RST};
    typedef struct packed {
        logic [7:0] code;
        logic [1:0] range;
        logic [1:0] ramp;
        logic [1:0] sst;
    } bsc_act_t;
    // Strap index order: 6.2k to GND, short GND, short supply, 47k to supply.
    function automatic logic [1:0] strap_idx(input logic [1:0] code);
        unique case (code)
            2'h1: strap_idx = 2'h0;
            2'h0: strap_idx = 2'h1;
            2'h3: strap_idx = 2'h2;
            default: strap_idx = 2'h3;
        endcase
    endfunction : strap_idx
    // Setpoint in 1.25 mV units above 0.4 V.
    function automatic logic [9:0] fine_of(input logic [7:0] c, input logic [1:0] r);
        unique case (r)
            2'h0: fine_of = {2'h0, c};
            2'h1: fine_of = {1'h0, c, 1'h0};
            default: fine_of = {c, 2'h0};
        endcase
    endfunction : fine_of
endpackage : bsc_pkg

// >>> verif/bsc_strap_model.sv
// Strap pin partner: a resistor or short on the pin, seen through the two test switches.
`timescale 1ns/1ps
`default_nettype none
module bsc_strap_model (
    input wire logic [1:0] i_opt,
    input wire logic i_sw_one,
    input wire logic i_sw_two,
    output logic o_level
);
    // Options: 0 is 6.2k to ground, 1 short to ground, 2 short to supply, 3 is 47k to supply.
    // Switch one pulls up and only overrides the resistor to ground; switch two pulls down.
    always_comb begin
        o_level = i_opt[1];
        if (i_sw_one && i_opt == 2'h0) o_level = 1'b1;
        if (i_sw_two && i_opt == 2'h3) o_level = 1'b0;
    end
endmodule : bsc_strap_model
`default_nettype wire

// >>> verif/bsc_core_properties.sv
// Port checks for the setpoint and clock configuration core.
`timescale 1ns/1ps
`default_nettype none
module bsc_core_properties (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_mode_sync,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_freq_sw_one,
    input wire logic o_freq_sw_two,
    input wire logic o_setp_sw_one,
    input wire logic o_setp_sw_two,
    input wire logic o_init_done,
    input wire logic [1:0] o_freq_sel,
    input wire logic [6:0] o_target_addr,
    input wire logic [9:0] o_vout_fine,
    input wire logic o_soft_start,
    input wire logic o_ramping,
    input wire logic o_forced_pwm,
    input wire logic o_ext_clock,
    input wire logic signed [4:0] o_freq_trim
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////
    a_fsw_excl: assert property (!(o_freq_sw_one && o_freq_sw_two))
        else $error("freq switches both closed");
    a_ssw_excl: assert property (!(o_setp_sw_one && o_setp_sw_two))
        else $error("setpoint switches both closed");
    a_strap_hold: assert property (o_init_done |=> o_init_done && $stable(o_freq_sel)
        && $stable(o_target_addr)) else $error("strap result moved");
    a_addr_table: assert property (o_init_done |-> o_target_addr[6:2] == 5'h11)
        else $error("address out of table");
    a_ramp_step: assert property (o_ramping && $past(o_ramping) && !o_soft_start
        && !$past(o_soft_start) && o_vout_fine != 10'h0 && $changed(o_vout_fine)
        |-> o_vout_fine == $past(o_vout_fine) + 10'h1 || o_vout_fine + 10'h1 == $past(o_vout_fine))
        else $error("ramp step not one unit");
    a_pin_forced: assert property ((i_mode_sync && !o_soft_start)[*5] |-> o_forced_pwm)
        else $error("high mode pin not forced");
    a_ext_forced: assert property ((o_ext_clock && !o_soft_start)[*3] |-> o_forced_pwm)
        else $error("external clock not forced");
    a_ext_nospread: assert property (o_ext_clock[*3] |-> o_freq_trim == 5'sd0)
        else $error("spread with external clock");
    a_trim_range: assert property (o_freq_trim >= -5'sd10 && o_freq_trim <= 5'sd10)
        else $error("trim out of range");
    a_trim_step: assert property (o_freq_trim != 5'sd0 && $past(o_freq_trim) != 5'sd0
        |-> o_freq_trim - $past(o_freq_trim) inside {5'sd0, 5'sd1, -5'sd1})
        else $error("trim jumped");
    a_err_ready: assert property (o_pslverr |-> o_pready) else $error("error without ready");
endmodule : bsc_core_properties
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench: straps, setpoint ramps, mode and spread control over APB.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import bsc_pkg::*;
    logic i_clk_sys = 0, i_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0, i_enable = 0;
    logic i_mode_sync = 0, i_stack_secondary = 0, err, i_freq_strap, i_setpoint_strap;
    logic [7:0] i_paddr = 0;
    logic [31:0] i_pwdata = 0, rd, o_prdata;
    logic [1:0] opt = 0, o_freq_sel;
    logic o_pready, o_pslverr, o_freq_sw_one, o_freq_sw_two, o_setp_sw_one, o_setp_sw_two;
    logic o_init_done, o_soft_start, o_ramping, o_forced_pwm, o_sync_pulse, o_ext_clock;
    logic o_droop_en;
    logic [6:0] o_target_addr;
    logic [9:0] o_vout_fine;
    logic signed [4:0] o_freq_trim, t;
    logic [7:0] codes [4] = '{8'h50, 8'h46, 8'h5f, 8'h24};
    int n_fail = 0, samples_checked = 0, cyc = 0, n, n_sp = 0;
    always #2.5 i_clk_sys = ~i_clk_sys;
    bsc_core bsc_core_inst (.*);
    bsc_strap_model freq_strap_inst (.i_opt(opt), .i_sw_one(o_freq_sw_one),
        .i_sw_two(o_freq_sw_two), .o_level(i_freq_strap));
    bsc_strap_model setp_strap_inst (.i_opt(opt), .i_sw_one(o_setp_sw_one),
        .i_sw_two(o_setp_sw_two), .o_level(i_setpoint_strap));
    ////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk_sys);
        i_penable <= 1'b1;
        do @(posedge i_clk_sys); while (o_pready !== 1'b1);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb
    // Counts ramp cycles so the slew is judged too.
    task automatic settle();
        n = 0;
        repeat (3) @(posedge i_clk_sys);
        while (o_ramping === 1'b1) begin
            @(posedge i_clk_sys);
            n++;
        end
    endtask : settle
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test
    // Soft-start alone takes about 99k cycles.
    always @(posedge i_clk_sys) begin
        cyc++;
        n_sp += (o_sync_pulse === 1'b1);
        if (cyc == 130000) begin
            n_fail++;
            stop_test();
        end
    end
    ////////////////////////////////////////
    initial begin
        for (int i = 0; i < 4; i++) begin
            @(posedge i_clk_sys);
            i_rst <= 1'b1;
            opt <= i[1:0];
            repeat (4) @(posedge i_clk_sys);
            i_rst <= 1'b0;
            while (o_init_done !== 1'b1) @(posedge i_clk_sys);
            repeat (2) @(posedge i_clk_sys);
            chk("freq_strap", o_freq_sel, i);
            chk("addr", o_target_addr, 32'h44 + i);
            apb(1'b0, OFS_SETP, 0);
            chk("setp", rd, codes[i]);
            apb(1'b0, OFS_STAT, 0);
            chk("stat", rd[3:0], {i[1:0], i[1:0]});
        end
        apb(1'b0, OFS_CTRL1, 0);
        chk("ctrl1", rd, 32'ha);
        apb(1'b0, OFS_CTRL2, 0);
        chk("ctrl2", rd, 32'h2);
        apb(1'b0, 8'h40, 0);
        chk("unmapped", {rd[30:0], err}, 32'h1);
        apb(1'b1, OFS_CTRL3, 1);
        repeat (2) @(posedge i_clk_sys);
        chk("droop", o_droop_en, 1);
        apb(1'b1, OFS_CTRL1, 32'h2);
        apb(1'b1, OFS_CTRL2, 0);
        i_enable <= 1'b1;
        repeat (10) @(posedge i_clk_sys);
        chk("ss", o_soft_start, 1);
        apb(1'b1, OFS_SETP, 32'h10);
        n = 0;
        while (o_soft_start === 1'b1) begin
            @(posedge i_clk_sys);
            n++;
        end
        chk("sstime", n > 99200 && n < 99400, 1);
        chk("ssend", o_vout_fine, 144);
        settle();
        chk("dvs", {o_vout_fine, n > 1950 && n < 2050}, {10'd64, 1'b1});
        t = 0;
        for (int r = 0; r < 4; r++) begin
            n = o_vout_fine;
            apb(1'b1, OFS_CTRL1, r);
            repeat (40) @(posedge i_clk_sys);
            chk("hold", o_vout_fine, n);
            apb(1'b1, OFS_SETP, 32'h30);
            settle();
            chk("range", o_vout_fine, 32'h30 << (r - (r == 3)));
        end
        apb(1'b1, OFS_SETP, 32'h10);
        apb(1'b1, OFS_SETP, 32'h20);
        settle();
        chk("first", o_vout_fine, 64);
        settle();
        chk("second", o_vout_fine, 128);
        apb(1'b1, OFS_CTRL1, 32'h23);
        repeat (10) @(posedge i_clk_sys);
        chk("psm", {o_forced_pwm, o_freq_trim}, 0);
        i_mode_sync <= 1'b1;
        repeat (10) @(posedge i_clk_sys);
        chk("forced_pwm_mode", o_forced_pwm, 1);
        t = o_freq_trim;
        repeat (520) @(posedge i_clk_sys);
        chk("trim", o_freq_trim !== t, 1);
        i_mode_sync <= 1'b0;
        apb(1'b1, OFS_CTRL1, 32'h33);
        repeat (10) @(posedge i_clk_sys);
        chk("bit", o_forced_pwm, 1);
        repeat (6) begin
            i_mode_sync <= 1'b1;
            repeat (50) @(posedge i_clk_sys);
            i_mode_sync <= 1'b0;
            repeat (50) @(posedge i_clk_sys);
        end
        chk("sync", {o_ext_clock, o_forced_pwm, o_freq_trim}, 32'h60);
        chk("pulses", n_sp, 3);
        repeat (300) @(posedge i_clk_sys);
        i_stack_secondary <= 1'b1;
        repeat (10) @(posedge i_clk_sys);
        chk("second", o_ext_clock, 1);
        stop_test();
    end
endmodule : testbench
bind bsc_core bsc_core_properties bsc_core_properties_inst (.*);
`default_nettype wire
